// >>> src/sec_pkg.sv
// constants for the input sample error checker
package sec_pkg;
  // ---------------------------------------------
  // register offsets
  // ---------------------------------------------
  localparam logic [7:0] SEC_PAT_BASE  = 8'h38;
  localparam logic [7:0] SEC_PAT_LAST  = 8'h3f;
  localparam logic [7:0] SEC_CTRL_ADDR = 8'h40;
  localparam logic [7:0] SEC_RISE_LO   = 8'h41;
  localparam logic [7:0] SEC_RISE_HI   = 8'h42;
  localparam logic [7:0] SEC_FALL_LO   = 8'h43;
  localparam logic [7:0] SEC_FALL_HI   = 8'h44;
  // ---------------------------------------------
  // control/status fields
  // ---------------------------------------------
  localparam int          SEC_B_ENABLE = 7;
  localparam int          SEC_B_DET_B  = 6;
  localparam int          SEC_B_DET_A  = 5;
  localparam int          SEC_B_AUTO   = 3;
  localparam int          SEC_B_FAIL_B = 2;
  localparam int          SEC_B_FAIL_A = 1;
  localparam int          SEC_B_PASS   = 0;
  localparam logic [7:0]  SEC_CTRL_RST = 8'h00;
  localparam logic [15:0] SEC_MAP_RST  = 16'h0000;
  localparam logic [7:0]  SEC_PAT_RST  = 8'h00;
  // ---------------------------------------------
  // sample set layout
  // ---------------------------------------------
  localparam int         SEC_WIDTH     = 16;
  localparam int         SEC_PORTS     = 2;
  localparam int         SEC_SAMPLES   = 4;
  localparam logic [1:0] SEC_LAST_POS  = 2'h3;
  localparam logic [3:0] SEC_GOOD_SETS = 4'h8;
endpackage : sec_pkg

// >>> src/sec_checker.sv
// input sample error checker with its register file
`timescale 1ns/1ps
module sec_checker
  import sec_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  input  wire logic                           input_data_clock,
  input  wire logic [sec_pkg::SEC_WIDTH-1:0]  port_a_data,
  input  wire logic [sec_pkg::SEC_WIDTH-1:0]  port_b_data,
  input  wire logic                           bank_sel,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  input  wire logic [7:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  output logic      [7:0]                     reg_rdata
);
  import sec_pkg::*;

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic                 dclk_s1_ff, dclk_s2_ff, dclk_s3_ff;
  logic [SEC_WIDTH-1:0] a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {dclk_s1_ff, dclk_s2_ff, dclk_s3_ff} <= 3'h0;
      {a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff} <= {4{SEC_MAP_RST}};
    end else if (ce) begin
      dclk_s1_ff <= input_data_clock;
      dclk_s2_ff <= dclk_s1_ff;
      dclk_s3_ff <= dclk_s2_ff;
      a_s1_ff    <= port_a_data;
      a_s2_ff    <= a_s1_ff;
      b_s1_ff    <= port_b_data;
      b_s2_ff    <= b_s1_ff;
    end
  end

  wire rise_edge = dclk_s2_ff & ~dclk_s3_ff;
  wire fall_edge = ~dclk_s2_ff & dclk_s3_ff;

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  logic [7:0]           pat_ff [SEC_PORTS][2*SEC_SAMPLES];
  logic                 en_ff, auto_ff, det_a_ff, det_b_ff;
  logic                 fail_a_ff, fail_b_ff, pass_ff;
  logic [SEC_WIDTH-1:0] rise_map_ff [SEC_PORTS];
  logic [SEC_WIDTH-1:0] fall_map_ff [SEC_PORTS];
  logic [1:0]           pos_ff;
  logic                 set_err_a_ff, set_err_b_ff;
  logic [3:0]           good_ff;
  logic                 armed_ff;
  logic [7:0]           rdata_ff;

  function automatic logic [SEC_WIDTH-1:0] pat_word(input logic port, input logic [1:0] idx);
    pat_word = {pat_ff[port][{idx, 1'b1}], pat_ff[port][{idx, 1'b0}]};
  endfunction : pat_word

  wire       wr_pat   = reg_wr && reg_addr >= SEC_PAT_BASE && reg_addr <= SEC_PAT_LAST;
  wire [2:0] pat_idx  = 3'(reg_addr - SEC_PAT_BASE);
  wire       wr_ctrl  = reg_wr && reg_addr == SEC_CTRL_ADDR;

  // ---------------------------------------------
  // compare path
  // ---------------------------------------------
  wire                 edge_hit = en_ff && armed_ff && (pos_ff[0] ? fall_edge : rise_edge);
  wire [SEC_WIDTH-1:0] err_a    = a_s2_ff ^ pat_word(1'b0, pos_ff);
  wire [SEC_WIDTH-1:0] err_b    = b_s2_ff ^ pat_word(1'b1, pos_ff);
  wire                 set_done = edge_hit && pos_ff == SEC_LAST_POS;
  wire                 nxt_fa   = set_err_a_ff | (|err_a);
  wire                 nxt_fb   = set_err_b_ff | (|err_b);
  wire                 set_good = set_done && !nxt_fa && !nxt_fb;
  wire                 auto_clr = set_good && auto_ff && good_ff >= SEC_GOOD_SETS - 4'h1;
  wire                 restart  = wr_ctrl && reg_wdata[SEC_B_ENABLE] && !en_ff;
  wire                 map_clr  = auto_clr || restart;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff    <= SEC_CTRL_RST[SEC_B_ENABLE];
      auto_ff  <= SEC_CTRL_RST[SEC_B_AUTO];
      armed_ff <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        en_ff   <= reg_wdata[SEC_B_ENABLE];
        auto_ff <= reg_wdata[SEC_B_AUTO];
      end
      // start a set only on a rising edge so sample 0 lines up
      if (!en_ff || restart)
        armed_ff <= 1'b0;
      else if (rise_edge)
        armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ff       <= 2'h0;
      set_err_a_ff <= 1'b0;
      set_err_b_ff <= 1'b0;
    end else if (ce) begin
      if (!armed_ff) begin
        pos_ff       <= 2'h0;
        set_err_a_ff <= 1'b0;
        set_err_b_ff <= 1'b0;
      end else if (edge_hit) begin
        pos_ff       <= 2'(pos_ff + 2'h1);
        set_err_a_ff <= set_done ? 1'b0 : nxt_fa;
        set_err_b_ff <= set_done ? 1'b0 : nxt_fb;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_a_ff <= SEC_CTRL_RST[SEC_B_FAIL_A];
      fail_b_ff <= SEC_CTRL_RST[SEC_B_FAIL_B];
      pass_ff   <= SEC_CTRL_RST[SEC_B_PASS];
      det_a_ff  <= SEC_CTRL_RST[SEC_B_DET_A];
      det_b_ff  <= SEC_CTRL_RST[SEC_B_DET_B];
      good_ff   <= 4'h0;
    end else if (ce) begin
      if (set_done) begin
        fail_a_ff <= nxt_fa;
        fail_b_ff <= nxt_fb;
        pass_ff   <= !nxt_fa && !nxt_fb;
      end
      if (map_clr) begin
        det_a_ff <= 1'b0;
        det_b_ff <= 1'b0;
      end else if (set_done) begin
        det_a_ff <= det_a_ff | nxt_fa;
        det_b_ff <= det_b_ff | nxt_fb;
      end
      // count saturates so a late auto-clear enable still fires on the next good set
      if (map_clr || (set_done && !set_good))
        good_ff <= 4'h0;
      else if (set_good && good_ff != SEC_GOOD_SETS)
        good_ff <= 4'(good_ff + 4'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < SEC_PORTS; p++) begin
        rise_map_ff[p] <= SEC_MAP_RST;
        fall_map_ff[p] <= SEC_MAP_RST;
        for (int i = 0; i < 2*SEC_SAMPLES; i++)
          pat_ff[p][i] <= SEC_PAT_RST;
      end
    end else if (ce) begin
      if (wr_pat)
        pat_ff[bank_sel][pat_idx] <= reg_wdata;
      if (map_clr) begin
        for (int p = 0; p < SEC_PORTS; p++) begin
          rise_map_ff[p] <= SEC_MAP_RST;
          fall_map_ff[p] <= SEC_MAP_RST;
        end
      end else if (edge_hit && !pos_ff[0]) begin
        rise_map_ff[0] <= rise_map_ff[0] | err_a;
        rise_map_ff[1] <= rise_map_ff[1] | err_b;
      end else if (edge_hit) begin
        fall_map_ff[0] <= fall_map_ff[0] | err_a;
        fall_map_ff[1] <= fall_map_ff[1] | err_b;
      end
    end
  end

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  wire [7:0] ctrl_rd = {en_ff, det_b_ff, det_a_ff, 1'b0, auto_ff, fail_b_ff, fail_a_ff, pass_ff};
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr >= SEC_PAT_BASE && reg_addr <= SEC_PAT_LAST)
      nxt_rdata = pat_ff[bank_sel][pat_idx];
    else if (reg_addr == SEC_CTRL_ADDR)
      nxt_rdata = ctrl_rd;
    else if (reg_addr == SEC_RISE_LO)
      nxt_rdata = rise_map_ff[bank_sel][7:0];
    else if (reg_addr == SEC_RISE_HI)
      nxt_rdata = rise_map_ff[bank_sel][15:8];
    else if (reg_addr == SEC_FALL_LO)
      nxt_rdata = fall_map_ff[bank_sel][7:0];
    else if (reg_addr == SEC_FALL_HI)
      nxt_rdata = fall_map_ff[bank_sel][15:8];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (ce && reg_rd)
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_off_no_compare: assert property (!en_ff |-> !edge_hit)
    else $error("compare ran while disabled");
  chk_detect_port_b: assert property (ce && set_done && nxt_fb && !map_clr |=> det_b_ff && fail_b_ff)
    else $error("port b error not flagged");
  chk_detect_port_a: assert property (ce && set_done && nxt_fa && !map_clr |=> det_a_ff && fail_a_ff)
    else $error("port a error not flagged");
  chk_auto_clear: assert property (ce && auto_clr |=> !det_a_ff && !det_b_ff && rise_map_ff[0] == SEC_MAP_RST)
    else $error("auto clear did not clear status");
  chk_no_auto_clr: assert property (ce && !auto_ff && !restart
                                    |=> (det_a_ff || !$past(det_a_ff)) && (det_b_ff || !$past(det_b_ff)))
    else $error("status cleared without auto clear");
  chk_fail_b_set: assert property (ce && set_done |=> fail_b_ff == $past(nxt_fb))
    else $error("port b fail bit wrong");
  chk_fail_a_set: assert property (ce && set_done |=> fail_a_ff == $past(nxt_fa))
    else $error("port a fail bit wrong");
  chk_pass_match: assert property (pass_ff |-> !fail_a_ff && !fail_b_ff)
    else $error("pass and fail both set");
  chk_rise_read: assert property (ce && reg_rd && reg_addr == SEC_RISE_HI
                                  |=> reg_rdata == $past(rise_map_ff[bank_sel][15:8]))
    else $error("rising map read mismatch");
  chk_fall_read: assert property (ce && reg_rd && reg_addr == SEC_FALL_LO
                                  |=> reg_rdata == $past(fall_map_ff[bank_sel][7:0]))
    else $error("falling map read mismatch");
  chk_map_sticky: assert property (!map_clr |=> (rise_map_ff[1] & $past(rise_map_ff[1])) == $past(rise_map_ff[1]))
    else $error("error map bit lost");
endmodule : sec_checker

// >>> tb/sec_host_model.sv
// host logic model driving the two sample ports
`timescale 1ns/1ps
module sec_host_model (
  input  wire logic             run,
  input  wire logic [3:0][15:0] pat_a,
  input  wire logic [3:0][15:0] pat_b,
  input  wire logic [3:0][15:0] err_a,
  input  wire logic [3:0][15:0] err_b,
  output logic                  dclk,
  output logic      [15:0]      data_a,
  output logic      [15:0]      data_b,
  output logic                  set_end
);
  // ---------------------------------------------
  // sample sets back to back, data clock toggles once per 80 ns sample with no gap between frames
  // ---------------------------------------------
  initial begin
    dclk = 1'b0;
    set_end = 1'b0;
    data_a = 16'h0000;
    data_b = 16'h0000;
    forever begin
      wait (run);
      for (int k = 0; k < 4; k++) begin
        data_a = pat_a[k] ^ err_a[k];
        data_b = pat_b[k] ^ err_b[k];
        #40;
        dclk = ~dclk;
        #39;
        set_end = (k == 3);
        #1;
      end
      set_end = 1'b0;
      if (!run) begin
        // released bus shows no stale value
        data_a = ~data_a;
        data_b = ~data_b;
      end
    end
  end
endmodule : sec_host_model

// >>> tb/tb_sec_checker.sv
// testbench for the input sample error checker
`timescale 1ns/1ps
module tb_sec_checker;
  import sec_pkg::*;
  logic clk, rst_n, ce, dclk, bank_sel, reg_wr, reg_rd, run, set_end;
  logic [15:0] data_a, data_b;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0][15:0] pat_a, pat_b, err_a, err_b;
  int fail_count, num_checks;
  // ---------------------------------------------
  // instances
  // ---------------------------------------------
  sec_checker i_sec_checker (.clk(clk), .rst_n(rst_n), .ce(ce), .input_data_clock(dclk),
    .port_a_data(data_a), .port_b_data(data_b), .bank_sel(bank_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  sec_host_model i_sec_host_model (.run(run), .pat_a(pat_a), .pat_b(pat_b), .err_a(err_a),
    .err_b(err_b), .dclk(dclk), .data_a(data_a), .data_b(data_b), .set_end(set_end));
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns read %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
  endtask : rd
  task automatic sets(input int n);
    repeat (n) @(posedge set_end);
    repeat (4) @(negedge clk);
  endtask : sets
  task automatic enable(input logic [7:0] v);
    // write between the two rising edges of a set so arming lands on sample 2
    sets(1);
    repeat (4) @(negedge clk);
    wr(SEC_CTRL_ADDR, v);
  endtask : enable
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // ---------------------------------------------
  // clock and watchdog
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // ---------------------------------------------
  // test sequence
  // ---------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    bank_sel = 1'b0;
    run = 1'b0;
    err_a = '0;
    err_b = '0;
    pat_a = {16'h3c96, 16'h7788, 16'ha5c3, 16'h1e0f};
    pat_b = {16'h0ff0, 16'hc35a, 16'h6699, 16'hf00d};
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    run = 1'b1;
    rd(SEC_CTRL_ADDR, SEC_CTRL_RST);
    for (int a = 0; a < 4; a++) rd(8'(SEC_RISE_LO + a), 8'h00);
    rd(8'h45, 8'h00);
    wr(SEC_RISE_LO, 8'hff);
    rd(SEC_RISE_LO, 8'h00);
    for (int b = 0; b < 2; b++) begin
      bank_sel = b[0];
      for (int k = 0; k < 4; k++) begin
        wr(8'(SEC_PAT_BASE + 2 * k), b ? pat_b[k][7:0] : pat_a[k][7:0]);
        wr(8'(SEC_PAT_BASE + 2 * k + 1), b ? pat_b[k][15:8] : pat_a[k][15:8]);
      end
    end
    rd(SEC_PAT_LAST, pat_b[3][15:8]);
    bank_sel = 1'b0;
    enable(8'h80);
    sets(3);
    rd(SEC_CTRL_ADDR, 8'h81);
    err_a[0] = 16'h0008;
    err_b[3] = 16'h8000;
    sets(2);
    rd(SEC_CTRL_ADDR, 8'he6);
    rd(SEC_RISE_LO, 8'h08);
    rd(SEC_FALL_HI, 8'h00);
    bank_sel = 1'b1;
    rd(SEC_FALL_HI, 8'h80);
    rd(SEC_RISE_LO, 8'h00);
    bank_sel = 1'b0;
    err_a = '0;
    err_b = '0;
    sets(9);
    rd(SEC_CTRL_ADDR, 8'he1);
    rd(SEC_RISE_LO, 8'h08);
    wr(SEC_CTRL_ADDR, 8'h88);
    sets(10);
    rd(SEC_CTRL_ADDR, 8'h89);
    rd(SEC_RISE_LO, 8'h00);
    wr(SEC_CTRL_ADDR, 8'h00);
    err_a[0] = 16'h0008;
    err_b[3] = 16'h8000;
    sets(2);
    rd(SEC_CTRL_ADDR, 8'h01);
    rd(SEC_RISE_LO, 8'h00);
    ce = 1'b0;
    wr(SEC_CTRL_ADDR, 8'h88);
    ce = 1'b1;
    rd(SEC_CTRL_ADDR, 8'h01);
    enable(8'h80);
    sets(3);
    rd(SEC_CTRL_ADDR, 8'he6);
    wrap_up();
  end
endmodule : tb_sec_checker
